// file: hdl/modem_device.sv
`default_nettype none

module modem_device #(
    parameter int unsigned BOOT_CYCLES = modem_pkg::BOOT_CYCLES_DEF
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    modem_link_if.device    link,
    input  wire logic       msg_arrived_i,
    input  wire logic       link_valid_i,
    input  wire logic       rx_ready_i,
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    input  wire logic       diag_rx_i,
    output logic            diag_tx_o,
    output logic [7:0]      diag_rx_data_o,
    output logic            diag_rx_valid_o,
    input  wire logic [7:0] diag_tx_data_i,
    input  wire logic       diag_tx_valid_i,
    output logic            diag_tx_ready_o,
    output logic [7:0]      queue_count_o
);

    // ----------------------------------------
    // Pin synchronisers {diag_rx, rts_n, rxd, power}
    // ----------------------------------------
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_meta <= modem_pkg::DEV_SYNC_RESET;
            pin_sync <= modem_pkg::DEV_SYNC_RESET;
        end else begin
            pin_meta <= {diag_rx_i, link.rts_n, link.host_to_dev, link.power_on_request};
            pin_sync <= pin_meta;
        end
    end

    wire power_s = pin_sync[0];
    wire rxd_s   = pin_sync[1];
    wire rts_n_s = pin_sync[2];
    wire diag_s  = pin_sync[3];

    // ----------------------------------------
    // Power state machine
    // ----------------------------------------
    modem_pkg::dev_state_e state;
    modem_pkg::dev_state_e next_state;
    logic [31:0]           phase_cnt;

    wire boot_done  = (phase_cnt == 32'(BOOT_CYCLES - 1));
    wire pulse_done = (phase_cnt == 32'(modem_pkg::READY_PULSE_CYCLES - 1));
    wire on         = (state != modem_pkg::ST_OFF);
    wire running    = (state == modem_pkg::ST_RUN);

    always_comb begin
        next_state = state;
        unique case (state)
            modem_pkg::ST_OFF: begin
                next_state = modem_pkg::ST_BOOT;
            end
            modem_pkg::ST_BOOT: begin
                if (boot_done) begin
                    next_state = modem_pkg::ST_READY;
                end
            end
            modem_pkg::ST_READY: begin
                if (pulse_done) begin
                    next_state = modem_pkg::ST_RUN;
                end
            end
            modem_pkg::ST_RUN: begin
                next_state = modem_pkg::ST_RUN;
            end
            default: begin
                next_state = modem_pkg::ST_OFF;
            end
        endcase
    end

    // Power enable low acts as reset and shuts everything down
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !power_s) begin // see RULE9
            state <= modem_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !on || (next_state != state)) begin
            phase_cnt <= 32'h0000_0000;
        end else begin
            phase_cnt <= phase_cnt + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // Host serial lane
    // ----------------------------------------
    logic       host_tx;
    logic       host_busy;
    logic [7:0] host_byte;
    logic       host_byte_valid;
    logic       flow_en;

    wire tx_start = tx_valid_i && tx_ready_o;

    uart_lane #(
        .BIT_CYCLES (modem_pkg::HOST_BIT_CYCLES)
    ) u_host_lane (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .en_i       (on),
        .rx_i       (rxd_s),
        .tx_o       (host_tx),
        .tx_data_i  (tx_data_i),
        .tx_start_i (tx_start),
        .tx_busy_o  (host_busy),
        .rx_data_o  (host_byte),
        .rx_valid_o (host_byte_valid)
    );

    // No new character while flow control holds us off
    assign tx_ready_o       = on && !host_busy && !(flow_en && rts_n_s); // see RULE7
    assign link.dev_to_host = on ? host_tx : 1'b0;

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    wire cmd_flow_on  = host_byte_valid && (host_byte == modem_pkg::CMD_FLOW_ON);
    wire cmd_flow_off = host_byte_valid && (host_byte == modem_pkg::CMD_FLOW_OFF);
    wire cmd_clear    = host_byte_valid && (host_byte == modem_pkg::CMD_QUEUE_CLEAR);
    wire is_cmd       = cmd_flow_on || cmd_flow_off || cmd_clear;

    // Flow control starts off and only a host packet turns it on
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !on) begin // see RULE6
            flow_en <= 1'b0;
        end else if (cmd_flow_on) begin // see RULE5
            flow_en <= 1'b1;
        end else if (cmd_flow_off) begin
            flow_en <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !on) begin
            rx_data_o  <= 8'h00;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= host_byte_valid && !is_cmd;
            if (host_byte_valid && !is_cmd) begin
                rx_data_o <= host_byte;
            end
        end
    end

    // CTS asserted from power-up; under flow control it follows our readiness
    assign link.cts_n = !on || (flow_en && !rx_ready_i); // see RULE1, RULE2, RULE3

    // ----------------------------------------
    // Inbound queue count, arrival wins over clear
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !on) begin
            queue_count_o <= 8'h00;
        end else if (cmd_clear) begin // see RULE14
            queue_count_o <= msg_arrived_i ? 8'h01 : 8'h00;
        end else if (msg_arrived_i && (queue_count_o != modem_pkg::QUEUE_MAX)) begin
            queue_count_o <= queue_count_o + 8'h01;
        end
    end

    // ----------------------------------------
    // Status outputs
    // ----------------------------------------
    logic next_waiting;

    always_comb begin
        next_waiting = 1'b0;
        if (state == modem_pkg::ST_READY) begin
            next_waiting = 1'b1; // see RULE12
        end else if (running) begin
            next_waiting = (queue_count_o != 8'h00); // see RULE13, RULE14
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !on) begin
            link.message_waiting <= 1'b0;
            link.link_available  <= 1'b0;
        end else begin
            link.message_waiting <= next_waiting;
            link.link_available  <= link_valid_i; // see RULE15
        end
    end

    // ----------------------------------------
    // Diagnostic port
    // ----------------------------------------
    logic diag_tx;
    logic diag_busy;

    uart_lane #(
        .BIT_CYCLES (modem_pkg::DIAG_BIT_CYCLES) // see RULE8
    ) u_diag_lane (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .en_i       (on),
        .rx_i       (diag_s),
        .tx_o       (diag_tx),
        .tx_data_i  (diag_tx_data_i),
        .tx_start_i (diag_tx_valid_i && diag_tx_ready_o),
        .tx_busy_o  (diag_busy),
        .rx_data_o  (diag_rx_data_o),
        .rx_valid_o (diag_rx_valid_o)
    );

    assign diag_tx_ready_o = on && !diag_busy;
    assign diag_tx_o       = on ? diag_tx : 1'b0;

endmodule

`default_nettype wire

// file: hdl/modem_host.sv
`default_nettype none

module modem_host #(
    parameter int unsigned SETTLE_CYCLES = modem_pkg::SETTLE_CYCLES_DEF
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    modem_link_if.host      link,
    input  wire logic       supply_good_i,
    input  wire logic       power_on_i,
    output logic            dev_ready_o,
    output logic            message_waiting_o,
    output logic            link_available_o,
    input  wire logic       rx_ready_i,
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o
);

    // ----------------------------------------
    // Pin synchronisers {rxd, link_avail, waiting, cts_n}
    // ----------------------------------------
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_meta <= modem_pkg::HOST_SYNC_RESET;
            pin_sync <= modem_pkg::HOST_SYNC_RESET;
        end else begin
            pin_meta <= {link.dev_to_host, link.link_available, link.message_waiting,
                         link.cts_n};
            pin_sync <= pin_meta;
        end
    end

    wire cts_n_s = pin_sync[0];
    assign message_waiting_o = pin_sync[1];
    assign link_available_o  = pin_sync[2];

    // ----------------------------------------
    // Power sequencing
    // ----------------------------------------
    logic [31:0] settle_cnt;
    logic        power_req;
    logic        seen_high;
    logic        flow_en;

    wire settled = (settle_cnt == 32'(SETTLE_CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !supply_good_i) begin
            settle_cnt <= 32'h0000_0000;
        end else if (!settled) begin // see RULE11
            settle_cnt <= settle_cnt + 32'h0000_0001;
        end
    end

    // Power-down waits until the device queue has been drained
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !supply_good_i) begin
            power_req <= 1'b0;
        end else if (power_on_i && settled) begin // see RULE10
            power_req <= 1'b1;
        end else if (!power_on_i && !message_waiting_o) begin // see RULE16, RULE17
            power_req <= 1'b0;
        end
    end

    assign link.power_on_request = power_req;

    // Ready after the first high-then-low of the waiting line
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !power_req) begin
            seen_high   <= 1'b0;
            dev_ready_o <= 1'b0;
        end else if (message_waiting_o) begin
            seen_high <= 1'b1;
        end else if (seen_high) begin // see RULE12
            dev_ready_o <= 1'b1;
        end
    end

    // ----------------------------------------
    // Serial lane and flow control
    // ----------------------------------------
    logic host_tx;
    logic busy;

    wire tx_start = tx_valid_i && tx_ready_o;

    uart_lane #(
        .BIT_CYCLES (modem_pkg::HOST_BIT_CYCLES)
    ) u_lane (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .en_i       (power_req),
        .rx_i       (pin_sync[3]),
        .tx_o       (host_tx),
        .tx_data_i  (tx_data_i),
        .tx_start_i (tx_start),
        .tx_busy_o  (busy),
        .rx_data_o  (rx_data_o),
        .rx_valid_o (rx_valid_o)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !power_req) begin
            flow_en <= 1'b0;
        end else if (tx_start && (tx_data_i == modem_pkg::CMD_FLOW_ON)) begin // see RULE5
            flow_en <= 1'b1;
        end else if (tx_start && (tx_data_i == modem_pkg::CMD_FLOW_OFF)) begin
            flow_en <= 1'b0;
        end
    end

    assign tx_ready_o       = dev_ready_o && !busy && !(flow_en && cts_n_s); // see RULE3
    assign link.host_to_dev = power_req ? host_tx : 1'b1;
    assign link.rts_n       = flow_en && !rx_ready_i; // see RULE2, RULE4

endmodule

`default_nettype wire

// file: hdl/uart_lane.sv
`default_nettype none

module uart_lane #(
    parameter int unsigned BIT_CYCLES = 868
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       en_i,
    input  wire logic       rx_i,
    output logic            tx_o,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_start_i,
    output logic            tx_busy_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o
);

    // ----------------------------------------
    // Transmitter: start, 8 data LSB first, stop
    // ----------------------------------------
    logic [9:0]  tx_sh;
    logic [3:0]  tx_bits;
    logic [15:0] tx_cnt;
    wire         tx_tick = (tx_cnt == 16'h0000);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !en_i) begin
            tx_busy_o <= 1'b0;
            tx_sh     <= 10'h3FF;
            tx_bits   <= 4'h0;
            tx_cnt    <= 16'h0000;
        end else if (!tx_busy_o) begin
            if (tx_start_i) begin
                tx_busy_o <= 1'b1;
                tx_sh     <= {1'b1, tx_data_i, 1'b0};
                tx_bits   <= 4'hA;
                tx_cnt    <= 16'(BIT_CYCLES - 1);
            end
        end else if (tx_tick) begin
            tx_sh     <= {1'b1, tx_sh[9:1]};
            tx_bits   <= tx_bits - 4'h1;
            tx_cnt    <= 16'(BIT_CYCLES - 1);
            tx_busy_o <= (tx_bits != 4'h1);
        end else begin
            tx_cnt <= tx_cnt - 16'h0001;
        end
    end

    assign tx_o = tx_busy_o ? tx_sh[0] : 1'b1;

    // ----------------------------------------
    // Receiver: mid-bit sampling, false start rejected
    // ----------------------------------------
    logic        rx_busy;
    logic [7:0]  rx_sh;
    logic [3:0]  rx_bits;
    logic [15:0] rx_cnt;
    wire         rx_tick = (rx_cnt == 16'h0000);

    always_ff @(posedge clk_i) begin
        rx_valid_o <= 1'b0;
        if (!rst_n_i || !en_i) begin
            rx_busy   <= 1'b0;
            rx_sh     <= 8'h00;
            rx_bits   <= 4'h0;
            rx_cnt    <= 16'h0000;
            rx_data_o <= 8'h00;
        end else if (!rx_busy) begin
            if (!rx_i) begin
                rx_busy <= 1'b1;
                rx_bits <= 4'h0;
                rx_cnt  <= 16'(BIT_CYCLES / 2);
            end
        end else if (rx_tick) begin
            rx_cnt  <= 16'(BIT_CYCLES - 1);
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits == 4'h0) begin
                rx_busy <= !rx_i;
            end else if (rx_bits == 4'h9) begin
                rx_busy    <= 1'b0;
                rx_valid_o <= rx_i;
                rx_data_o  <= rx_i ? rx_sh : rx_data_o;
            end else begin
                rx_sh <= {rx_i, rx_sh[7:1]};
            end
        end else begin
            rx_cnt <= rx_cnt - 16'h0001;
        end
    end

endmodule

`default_nettype wire

// file: inc/modem_link_if.sv
`default_nettype none

interface modem_link_if;
    logic power_on_request;
    logic host_to_dev;
    logic dev_to_host;
    logic rts_n;
    logic cts_n;
    logic message_waiting;
    logic link_available;

    modport device (
        input  power_on_request,
        input  host_to_dev,
        input  rts_n,
        output dev_to_host,
        output cts_n,
        output message_waiting,
        output link_available
    );

    modport host (
        output power_on_request,
        output host_to_dev,
        output rts_n,
        input  dev_to_host,
        input  cts_n,
        input  message_waiting,
        input  link_available
    );
endinterface

`default_nettype wire

// file: inc/modem_pkg.sv
// Function
// RULE1 - Power-up: RTS input, CTS output, CTS asserted
// RULE2 - RTS and CTS asserted low, deasserted high
// RULE3 - Flow on: device asserts CTS when accepting
// RULE4 - Flow on: host asserts RTS when accepting
// RULE5 - Flow control enabled only by host packet
// RULE6 - Flow control disabled after reset
// RULE7 - Flow on, RTS deasserted: no new character
// RULE8 - Diagnostic port fixed at 115200 baud
// RULE9 - Power enable high keeps device on
// RULE10 - Host applies supply first, then power enable
// RULE11 - Host waits about 10 ms after supply
// RULE12 - Device toggles message_waiting once when ready
// RULE13 - message_waiting high while inbound queue nonempty
// RULE14 - message_waiting low only after queue cleared
// RULE15 - link_available high on valid downlink only
// RULE16 - Host powers down by dropping power enable
// RULE17 - Host empties pending messages before power-down
`default_nettype none

package modem_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ             = 100_000_000;
    localparam int unsigned DIAG_BAUD          = 115_200;
    localparam int unsigned DIAG_BIT_CYCLES    = CLK_HZ / DIAG_BAUD;
    localparam int unsigned HOST_BAUD          = 115_200;
    localparam int unsigned HOST_BIT_CYCLES    = CLK_HZ / HOST_BAUD;
    localparam int unsigned BOOT_TIME_MS       = 5000;
    localparam int unsigned BOOT_CYCLES_DEF    = BOOT_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned READY_PULSE_US     = 100;
    localparam int unsigned READY_PULSE_CYCLES = READY_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SETTLE_TIME_MS     = 10;
    localparam int unsigned SETTLE_CYCLES_DEF  = SETTLE_TIME_MS * (CLK_HZ / 1000);

    // ----------------------------------------
    // Host command bytes
    // ----------------------------------------
    localparam logic [7:0] CMD_FLOW_ON     = 8'hF1;
    localparam logic [7:0] CMD_FLOW_OFF    = 8'hF0;
    localparam logic [7:0] CMD_QUEUE_CLEAR = 8'hF2;

    // ----------------------------------------
    // Reset values, queue limit and device states
    // ----------------------------------------
    localparam logic [3:0] DEV_SYNC_RESET  = 4'hE;
    localparam logic [3:0] HOST_SYNC_RESET = 4'h9;
    localparam logic [7:0] QUEUE_MAX       = 8'hFF;

    typedef enum logic [3:0] {
        ST_OFF   = 4'b0001,
        ST_BOOT  = 4'b0010,
        ST_READY = 4'b0100,
        ST_RUN   = 4'b1000
    } dev_state_e;

endpackage

`default_nettype wire

// file: verif/modem_host_port_control_properties.sv
`default_nettype none

module modem_host_port_control_properties #(
    parameter int BOOT_CYCLES = 200
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic power_on_request,
    input wire logic host_to_dev,
    input wire logic dev_to_host,
    input wire logic rts_n,
    input wire logic cts_n,
    input wire logic message_waiting,
    input wire logic link_available
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int BOOT_LO = BOOT_CYCLES;
    localparam int BOOT_HI = BOOT_CYCLES + 8;

    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic [15:0] mw_run;
    logic [15:0] since_low;
    logic        booted;
    logic        mw_q;

    // Length of the current waiting run and whether the ready pulse is over
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !power_on_request) begin
            mw_run <= 16'h0000;
            booted <= 1'b0;
            mw_q   <= 1'b0;
        end else begin
            mw_q   <= message_waiting;
            mw_run <= message_waiting ? mw_run + 16'h0001 : 16'h0000;
            booted <= booted | (mw_q & ~message_waiting);
        end
    end

    // Cycles since the host line was last low
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !host_to_dev) begin
            since_low <= 16'h0000;
        end else if (since_low != 16'hFFFF) begin
            since_low <= since_low + 16'h0001;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_OFF_CTS: assert property (!power_on_request [*5] |-> cts_n)
        else $error("CTS asserted while powered off");
    AST_OFF_OUTS: assert property (!power_on_request [*5]
        |-> !message_waiting && !link_available && !dev_to_host)
        else $error("Outputs active while powered off");
    AST_DOWN_CTS: assert property ($fell(power_on_request) |-> ##[1:5] cts_n)
        else $error("CTS not released after power down");
    AST_BOOT_CTS: assert property ($rose(power_on_request) |-> ##[1:5] !cts_n)
        else $error("CTS not asserted low at power up");
    AST_BOOT_QUIET: assert property ($rose(power_on_request) |-> !message_waiting [*8])
        else $error("Waiting output high at start of boot");
    AST_READY_RISE: assert property ($rose(power_on_request)
        |-> ##[BOOT_LO:BOOT_HI] $rose(message_waiting))
        else $error("Ready toggle missing after boot");
    AST_READY_LEN: assert property (mw_q && !message_waiting && !booted
        |-> mw_run == 16'(modem_pkg::READY_PULSE_CYCLES))
        else $error("Ready toggle has wrong length");
    AST_CLEAR_FIRST: assert property (mw_q && !message_waiting && booted
        |-> since_low <= 16'(10 * modem_pkg::HOST_BIT_CYCLES))
        else $error("Waiting output fell without host traffic");

    cover property ($rose(power_on_request));
    cover property (mw_q && !message_waiting && booted);
    cover property (power_on_request && $rose(cts_n));
endmodule

`default_nettype wire

// file: verif/modem_host_port_control_tb.sv
`default_nettype none
`define CHK(nm, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
end

module modem_host_port_control_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int BOOT   = 200;
    localparam int SETTLE = 20;

    logic       clk_i, rst_n_i, supply, pwr_on, msg, lvalid, d_rdy, h_rdy;
    logic       d_txv, h_txv, g_txv;
    logic [7:0] d_txd, h_txd, g_txd;
    logic       d_rxv, h_rxv, g_rxv, d_txr, h_txr, g_txr, dev_rdy, h_mw, h_la;
    logic [7:0] d_rxd, h_rxd, g_rxd, qcnt;
    wire        diag_line;
    int         mismatches = 0;
    int         cmp_count  = 0;
    int         d_rx_cnt   = 0;
    int         mw_rises   = 0;
    int         n;
    logic       mw_prev    = 1'b0;

    modem_link_if link();

    modem_device #(.BOOT_CYCLES(BOOT)) u_modem_device (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .msg_arrived_i(msg),
        .link_valid_i(lvalid), .rx_ready_i(d_rdy), .rx_data_o(d_rxd), .rx_valid_o(d_rxv),
        .tx_data_i(d_txd), .tx_valid_i(d_txv), .tx_ready_o(d_txr), .diag_rx_i(diag_line),
        .diag_tx_o(diag_line), .diag_rx_data_o(g_rxd), .diag_rx_valid_o(g_rxv),
        .diag_tx_data_i(g_txd), .diag_tx_valid_i(g_txv), .diag_tx_ready_o(g_txr),
        .queue_count_o(qcnt));

    modem_host #(.SETTLE_CYCLES(SETTLE)) u_modem_host (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .supply_good_i(supply),
        .power_on_i(pwr_on), .dev_ready_o(dev_rdy), .message_waiting_o(h_mw),
        .link_available_o(h_la), .rx_ready_i(h_rdy), .rx_data_o(h_rxd), .rx_valid_o(h_rxv),
        .tx_data_i(h_txd), .tx_valid_i(h_txv), .tx_ready_o(h_txr));

    modem_host_port_control_properties #(.BOOT_CYCLES(BOOT)) u_modem_host_port_control_properties (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .power_on_request(link.power_on_request),
        .host_to_dev(link.host_to_dev), .dev_to_host(link.dev_to_host), .rts_n(link.rts_n),
        .cts_n(link.cts_n), .message_waiting(link.message_waiting),
        .link_available(link.link_available));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Delivered bytes and waiting-output rises, sampled away from the active edge
    always @(negedge clk_i) begin
        if (d_rxv === 1'b1) d_rx_cnt++;
        if (link.message_waiting === 1'b1 && mw_prev !== 1'b1) mw_rises++;
        mw_prev = link.message_waiting;
    end

    function automatic logic probe(input int k);
        case (k)
            0: return h_txr;
            1: return d_txr;
            2: return g_txr;
            3: return dev_rdy;
            4: return d_rxv;
            5: return h_rxv;
            6: return g_rxv;
            7: return link.power_on_request;
            8: return !link.message_waiting;
            9: return link.cts_n;
            default: return !link.power_on_request;
        endcase
    endfunction

    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_hi(input int k, input int lim);
        int c;
        c = 0;
        while (probe(k) !== 1'b1 && c < lim) begin
            tick(1);
            c++;
        end
        if (c >= lim) begin
            mismatches++;
            $display("MISMATCH wait %0d exp 1 got %b", k, probe(k));
            print_verdict();
        end
    endtask

    // Lane 0 host, 1 device, 2 diagnostic; valid held until the taking edge
    task automatic send(input int k, input logic [7:0] b);
        h_txd = b;
        d_txd = b;
        g_txd = b;
        h_txv = (k == 0);
        d_txv = (k == 1);
        g_txv = (k == 2);
        wait_hi(k, 20000);
        tick(1);
        h_txv = 1'b0;
        d_txv = 1'b0;
        g_txv = 1'b0;
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        {rst_n_i, supply, pwr_on, msg, lvalid, d_txv, h_txv, g_txv} = 8'h00;
        {d_rdy, h_rdy} = 2'b11;
        {d_txd, h_txd, g_txd} = 24'h000000;
        tick(8);
        rst_n_i = 1'b1;
        tick(3);
        `CHK("cts_off", 1'b1, link.cts_n);
        `CHK("por_rst", 1'b0, link.power_on_request);
        `CHK("rts_rst", 1'b0, link.rts_n);
        supply = 1'b1;
        pwr_on = 1'b1;
        tick(SETTLE / 2);
        `CHK("por_settle", 1'b0, link.power_on_request);
        wait_hi(7, 200);
        tick(6);
        `CHK("cts_boot", 1'b0, link.cts_n);
        wait_hi(3, 20000);
        `CHK("ready_toggles", 1, mw_rises);
        `CHK("mw_after_ready", 1'b0, link.message_waiting);
        send(2, 8'hFF);
        n = 0;
        while (diag_line === 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        n = 0;
        while (diag_line === 1'b0 && n < 2000) begin
            tick(1);
            n++;
        end
        `CHK("diag_bit", modem_pkg::DIAG_BIT_CYCLES, n);
        wait_hi(6, 10000);
        `CHK("diag_rx", 8'hFF, g_rxd);
        send(0, 8'h5A);
        wait_hi(4, 10000);
        `CHK("dev_rx", 8'h5A, d_rxd);
        send(1, 8'hA5);
        wait_hi(5, 10000);
        `CHK("host_rx", 8'hA5, h_rxd);
        msg = 1'b1;
        tick(2);
        msg = 1'b0;
        tick(4);
        `CHK("queue", 8'h02, qcnt);
        `CHK("mw_queue", 1'b1, h_mw);
        lvalid = 1'b1;
        tick(4);
        `CHK("la_on", 1'b1, h_la);
        lvalid = 1'b0;
        tick(4);
        `CHK("la_off", 1'b0, link.link_available);
        pwr_on = 1'b0;
        tick(50);
        `CHK("por_pending", 1'b1, link.power_on_request);
        pwr_on = 1'b1;
        `CHK("mw_hold", 1'b1, link.message_waiting);
        send(0, modem_pkg::CMD_QUEUE_CLEAR);
        wait_hi(8, 12000);
        `CHK("queue_clr", 8'h00, qcnt);
        d_rdy = 1'b0;
        tick(3);
        `CHK("cts_flow_off", 1'b0, link.cts_n);
        send(0, modem_pkg::CMD_FLOW_ON);
        wait_hi(9, 12000);
        `CHK("cts_busy", 1'b1, link.cts_n);
        d_rdy = 1'b1;
        tick(2);
        `CHK("cts_ready", 1'b0, link.cts_n);
        h_rdy = 1'b0;
        tick(2);
        `CHK("rts_busy", 1'b1, link.rts_n);
        d_txd = 8'hC3;
        d_txv = 1'b1;
        tick(3000);
        `CHK("tx_held", 1'b0, d_txr);
        `CHK("line_idle", 1'b1, link.dev_to_host);
        h_rdy = 1'b1;
        send(1, 8'hC3);
        wait_hi(5, 12000);
        `CHK("host_rx_held", 8'hC3, h_rxd);
        h_rdy = 1'b0;
        send(0, modem_pkg::CMD_FLOW_OFF);
        `CHK("rts_flow_off", 1'b0, link.rts_n);
        tick(9000);
        d_rdy = 1'b0;
        tick(2);
        `CHK("cts_after_off", 1'b0, link.cts_n);
        `CHK("tx_free", 1'b1, d_txr);
        pwr_on = 1'b0;
        wait_hi(10, 100);
        tick(6);
        `CHK("cts_down", 1'b1, link.cts_n);
        `CHK("tx_down", 1'b0, link.dev_to_host);
        `CHK("bytes_delivered", 1, d_rx_cnt);
        print_verdict();
    end
endmodule

`default_nettype wire
